/* inc/fic_pkg.sv */
/*
 * fic_pkg: constants, state encodings and coding functions shared by the
 * error-correction codec and its receive-side queue.
 * Assumes one synchronous clock domain; no other package is needed.
 */
package fic_pkg;

    // ************************************************************
    // geometry and code constants
    // ************************************************************
    localparam int          FIC_BYTE_BITS  = 8;
    localparam int          FIC_MAT_DIM    = 4;   // interleaver is dim x dim bits
    localparam int          FIC_MAT_BITS   = FIC_MAT_DIM * FIC_MAT_DIM;
    localparam int          FIC_CONSTRAINT = 4;   // taps over input bit plus 3 memory bits
    localparam int          FIC_FIFO_DEPTH = 16;
    localparam logic [3:0]  FIC_GEN_A      = 4'h8;  // tap mask {u, s0, s1, s2}
    localparam logic [3:0]  FIC_GEN_B      = 4'hD;
    localparam logic [2:0]  FIC_ENC_RESET  = 3'h0;
    localparam logic [3:0]  FIC_LAST_CODED = 4'hF;  // last bit of a 16-bit matrix
    localparam logic [3:0]  FIC_LAST_PLAIN = 4'h7;  // last bit of a plain byte
    localparam logic [1:0]  FIC_PAD_ODD    = 2'h1;  // pad bytes after an odd count
    localparam logic [1:0]  FIC_PAD_EVEN   = 2'h2;  // pad bytes after an even count
    localparam logic [7:0]  FIC_PAD_BYTE   = 8'h00;

    // ************************************************************
    // state encodings, gray along the usual path except rx push back to idle
    // ************************************************************
    typedef enum logic [1:0] {
        FIC_TX_IDLE = 2'b00,
        FIC_TX_SEND = 2'b01,
        FIC_TX_PAD  = 2'b11
    } fic_tx_e;

    typedef enum logic [1:0] {
        FIC_RX_IDLE    = 2'b00,
        FIC_RX_COLLECT = 2'b01,
        FIC_RX_PUSH    = 2'b11
    } fic_rx_e;

    // ************************************************************
    // coding functions
    // ************************************************************
    // one byte, msb first, through the encoder: {next memory, 16 coded bits}
    function automatic logic [18:0] fic_encode(input logic [7:0] b, input logic [2:0] s);
        logic [2:0]  st;
        logic [3:0]  sh;
        logic [15:0] c;
        st = s;
        c  = '0;
        sh = '0;
        for (int i = 0; i < FIC_BYTE_BITS; i++) begin
            sh           = {b[7-i], st};
            c[2*i]       = ^(sh & FIC_GEN_A);
            c[2*i+1]     = ^(sh & FIC_GEN_B);
            st           = sh[3:1];
        end
        return {st, c};
    endfunction : fic_encode

    // matrix transpose: written by rows, read by columns (its own inverse)
    function automatic logic [15:0] fic_transpose(input logic [15:0] v);
        logic [15:0] o;
        logic [3:0]  j;
        o = '0;
        for (int k = 0; k < FIC_MAT_BITS; k++) begin
            j    = 4'(k);
            o[k] = v[{j[1:0], j[3:2]}];
        end
        return o;
    endfunction : fic_transpose

    // systematic bits of a coded matrix back to a byte, msb first
    function automatic logic [7:0] fic_unsys(input logic [15:0] c);
        logic [7:0] b;
        b = '0;
        for (int i = 0; i < FIC_BYTE_BITS; i++) begin
            b[7-i] = c[2*i];
        end
        return b;
    endfunction : fic_unsys

endpackage : fic_pkg

/* inc/fic_stream_if.sv */
/*
 * fic_stream_if: valid/ready word channel between the codec core and its queue.
 * Assumes both ends share the codec clock.
 */
`timescale 1ns/100ps
interface fic_stream_if #(parameter int WIDTH = 8);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : fic_stream_if

/* src/fic_fifo.sv */
/*
 * fic_fifo: flip-flop queue, width and depth set by parameters.
 * Assumes a power-of-two depth and that both sides run on ref_clk.
 */
`timescale 1ns/100ps
module fic_fifo
    import fic_pkg::*;
#(
    parameter int WIDTH = FIC_BYTE_BITS,
    parameter int DEPTH = FIC_FIFO_DEPTH
) (
    input  wire logic   ref_clk,  // codec clock
    input  wire logic   resetn,   // async reset, active low
    fic_stream_if.snk   wr,       // filling side
    fic_stream_if.src   rd        // draining side
);
    localparam int AW = $clog2(DEPTH);

    // ************************************************************
    // parameter check
    // ************************************************************
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
        $error("fic_fifo: depth must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } fic_fifo_s;

    fic_fifo_s s_q, s_d;
    logic      push, pop;

    // ************************************************************
    // handshakes and next state
    // ************************************************************
    // full and empty come straight from the count, so ready is honest
    assign wr.ready = (s_q.cnt != (AW+1)'(DEPTH));
    assign rd.valid = (s_q.cnt != '0);
    assign rd.data  = s_q.mem[s_q.rp];
    assign push     = wr.valid && wr.ready;
    assign pop      = rd.valid && rd.ready;

    // pointer and count update
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = wr.data;
            s_d.wp          = s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = s_q.rp + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // state register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_fifo_count_bound: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_q.cnt <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
    c_fifo_full: cover property (@(posedge ref_clk) disable iff (!resetn) !wr.ready);

endmodule : fic_fifo

/* src/fic_codec.sv */
/*
 * fic_codec: rate one-half convolutional coder with 4x4 matrix interleaving
 * between the packet handler and the modem bit stream, and the reverse path.
 * Assumes all inputs synchronous to ref_clk and a fixed packet length.
 */
`timescale 1ns/100ps
module fic_codec
    import fic_pkg::*;
#(
    parameter int FIFO_DEPTH = FIC_FIFO_DEPTH
) (
    input  wire logic       ref_clk,               // 10 MHz codec clock
    input  wire logic       resetn,                // async reset, active low
    input  wire logic       errorCorrectionEnable, // coding on for new bytes/packets
    input  wire logic       txValid,               // byte from packet handler
    input  wire logic [7:0] txData,                // byte value
    input  wire logic       txLast,                // last coded byte (crc end)
    input  wire logic       txCoded,               // byte belongs to data/crc field
    output logic            txReady,               // codec idle, an offered byte is taken this cycle
    output logic            txBitValid,            // bit to modem valid
    output logic            txBit,                 // bit to modem
    input  wire logic       txBitReady,            // modem takes the bit
    input  wire logic       rxStart,               // sync found, packet follows
    input  wire logic [7:0] rxLen,                 // payload plus crc bytes
    input  wire logic       rxBitValid,            // bit from modem valid
    input  wire logic       rxBit,                 // bit from modem
    output logic            rxBitReady,            // codec takes the bit
    output logic            rxByteValid,           // byte to receive fifo valid
    output logic [7:0]      rxByteData,            // byte to receive fifo
    input  wire logic       rxByteReady,           // receive fifo takes byte
    output logic            rxCodeErr              // parity mismatch on a byte
);

    // ************************************************************
    // parameter check
    // ************************************************************
    if (FIFO_DEPTH < 2) begin : g_bad
        $error("fic_codec: queue depth below 2");
    end

    typedef struct packed {
        fic_tx_e     txState;
        logic [15:0] txMat;       // transmit order, bit 0 goes out first
        logic [3:0]  txCnt;
        logic        txCodedMode;
        logic [2:0]  encState;
        logic        txParity;    // odd count of coded bytes so far
        logic [1:0]  padLeft;
        fic_rx_e     rxState;
        logic [15:0] rxMat;       // received order, newest at bit 15
        logic [3:0]  rxCnt;
        logic        rxCodedMode;
        logic [2:0]  decState;
        logic [8:0]  byteIdx;
        logic [8:0]  byteTotal;
        logic [7:0]  lenQ;
        logic [7:0]  pushData;
        logic        pushKeep;
        logic        codeErr;
    } fic_core_s;

    fic_core_s    s_q, s_d;
    fic_stream_if #(.WIDTH(FIC_BYTE_BITS)) qIn ();
    fic_stream_if #(.WIDTH(FIC_BYTE_BITS)) qOut ();

    logic         txTake, txBitTake, txDone, rxBitTake, rxDone;
    logic [7:0]   encIn;
    logic [18:0]  encOut, decChk;
    logic [15:0]  rxShift, rxCodedBits;
    logic [7:0]   rxDecoded;
    logic [7:0]   txRev;

    // ************************************************************
    // handshakes and datapath helpers
    // ************************************************************
    assign txReady     = (s_q.txState == FIC_TX_IDLE);
    assign txTake      = txValid && txReady;
    assign txBitValid  = (s_q.txState == FIC_TX_SEND);
    assign txBit       = s_q.txMat[0];
    assign txBitTake   = txBitValid && txBitReady;
    assign txDone      = txBitTake && (s_q.txCnt == (s_q.txCodedMode ? FIC_LAST_CODED
                                                                     : FIC_LAST_PLAIN));
    // receive stalls while a byte waits for the queue
    assign rxBitReady  = (s_q.rxState == FIC_RX_COLLECT);
    assign rxBitTake   = rxBitValid && rxBitReady;
    assign rxDone      = rxBitTake && (s_q.rxCnt == (s_q.rxCodedMode ? FIC_LAST_CODED
                                                                      : FIC_LAST_PLAIN));
    assign rxShift     = {rxBit, s_q.rxMat[15:1]};
    // plain byte reversed so its msb leaves first from bit 0
    assign txRev       = {<<{txData}};

    // shared generator taps for both directions
    assign encIn       = (s_q.txState == FIC_TX_PAD) ? FIC_PAD_BYTE : txData;
    assign encOut      = fic_encode(encIn, s_q.encState);
    assign rxCodedBits = fic_transpose(rxShift);
    assign rxDecoded   = fic_unsys(rxCodedBits);
    assign decChk      = fic_encode(rxDecoded, s_q.decState);

    // queue toward the receive fifo
    assign qIn.valid   = (s_q.rxState == FIC_RX_PUSH) && s_q.pushKeep;
    assign qIn.data    = s_q.pushData;
    assign rxByteValid = qOut.valid;
    assign rxByteData  = qOut.data;
    assign qOut.ready  = rxByteReady;
    assign rxCodeErr   = s_q.codeErr;

    // ************************************************************
    // next-state logic
    // ************************************************************
    // transmit and receive paths share one state record
    always_comb begin
        s_d         = s_q;
        s_d.codeErr = 1'b0;

        // transmit: load a byte, its code, or a pad, then shift it out
        case (s_q.txState)
            FIC_TX_IDLE: begin
                if (txTake) begin
                    s_d.txState = FIC_TX_SEND;
                    s_d.txCnt   = '0;
                    if (errorCorrectionEnable && txCoded) begin
                        s_d.txCodedMode = 1'b1;
                        s_d.txMat       = fic_transpose(encOut[15:0]);
                        s_d.encState    = encOut[18:16];
                        s_d.txParity    = !s_q.txParity;
                        if (txLast) begin
                            // termination plus padding to an even byte count
                            s_d.padLeft = s_q.txParity ? FIC_PAD_EVEN
                                                       : FIC_PAD_ODD;
                        end
                    end else begin
                        // header bytes and bypass go msb first, no code
                        s_d.txCodedMode = 1'b0;
                        s_d.txMat       = {8'h00, txRev};
                        s_d.encState    = FIC_ENC_RESET;
                        s_d.txParity    = 1'b0;
                        s_d.padLeft     = '0;
                    end
                end
            end
            FIC_TX_SEND: begin
                if (txBitTake) begin
                    s_d.txMat = {1'b0, s_q.txMat[15:1]};
                    s_d.txCnt = s_q.txCnt + 4'h1;
                end
                if (txDone) begin
                    s_d.txState = (s_q.padLeft != '0) ? FIC_TX_PAD : FIC_TX_IDLE;
                end
            end
            FIC_TX_PAD: begin
                // zero bytes flush the coder memory back to all zeros
                s_d.txCodedMode = 1'b1;
                s_d.txMat       = fic_transpose(encOut[15:0]);
                s_d.encState    = encOut[18:16];
                s_d.padLeft     = s_q.padLeft - 2'h1;
                s_d.txCnt       = '0;
                s_d.txState     = FIC_TX_SEND;
                if (s_q.padLeft == 2'h1) begin
                    s_d.txParity = 1'b0;
                end
            end
            default: s_d.txState = FIC_TX_IDLE;
        endcase

        // receive: a new sync restarts the packet whatever the state
        if (rxStart) begin
            s_d.rxCodedMode = errorCorrectionEnable;
            s_d.lenQ        = rxLen;
            s_d.byteIdx     = '0;
            s_d.byteTotal   = errorCorrectionEnable
                            ? {1'b0, rxLen} + (rxLen[0] ? 9'h001 : 9'h002)
                            : {1'b0, rxLen};
            s_d.decState    = FIC_ENC_RESET;
            s_d.rxCnt       = '0;
            s_d.rxState     = (rxLen != 8'h00) ? FIC_RX_COLLECT : FIC_RX_IDLE;
        end else begin
            case (s_q.rxState)
                FIC_RX_IDLE: s_d.rxState = FIC_RX_IDLE;
                FIC_RX_COLLECT: begin
                    if (rxBitTake) begin
                        s_d.rxMat = rxShift;
                        s_d.rxCnt = s_q.rxCnt + 4'h1;
                    end
                    if (rxDone) begin
                        if (s_q.rxCodedMode) begin
                            s_d.pushData = rxDecoded;
                            s_d.decState = decChk[18:16];
                            s_d.codeErr  = (decChk[15:0] != rxCodedBits);
                        end else begin
                            s_d.pushData = {<<{rxShift[15:8]}};
                        end
                        // bytes past the payload are termination or pad
                        s_d.pushKeep = (s_q.byteIdx < {1'b0, s_q.lenQ});
                        s_d.byteIdx  = s_q.byteIdx + 9'h001;
                        s_d.rxCnt    = '0;
                        s_d.rxState  = FIC_RX_PUSH;
                    end
                end
                FIC_RX_PUSH: begin
                    if (!s_q.pushKeep || qIn.ready) begin
                        s_d.rxState = (s_q.byteIdx == s_q.byteTotal) ? FIC_RX_IDLE
                                                                     : FIC_RX_COLLECT;
                    end
                end
                default: s_d.rxState = FIC_RX_IDLE;
            endcase
        end
    end

    // state register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // receive queue
    // ************************************************************
    fic_fifo #(
        .WIDTH (FIC_BYTE_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_queue (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .wr      (qIn),
        .rd      (qOut)
    );

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_bypass_plain_byte: assert property (
        txTake && !errorCorrectionEnable |=> !s_q.txCodedMode && txBitValid)
        else $error("bypass byte was coded");
    a_header_uncoded: assert property (
        txTake && !txCoded |=> !s_q.txCodedMode && s_q.txMat[7:0] == $past(txRev))
        else $error("header byte not sent plain");
    a_rate_half_len: assert property (
        txBitTake && s_q.txCodedMode && s_q.txCnt != FIC_LAST_CODED |=> txBitValid)
        else $error("coded byte ended before sixteen bits");
    a_tx_interleave: assert property (
        txTake && errorCorrectionEnable && txCoded
        |=> s_q.txMat == fic_transpose($past(encOut[15:0])) && s_q.txCnt == 4'h0)
        else $error("transmit matrix not read by columns");
    a_rx_deinterleave: assert property (
        rxDone && s_q.rxCodedMode
        |=> s_q.rxState == FIC_RX_PUSH && s_q.pushData == fic_unsys($past(rxCodedBits)))
        else $error("receive matrix not read by columns");
    a_pad_count: assert property (
        txTake && errorCorrectionEnable && txCoded && txLast
        |=> s_q.padLeft == ($past(s_q.txParity) ? FIC_PAD_EVEN : FIC_PAD_ODD))
        else $error("wrong number of pad bytes");
    a_pad_zero_flush: assert property (
        s_q.txState == FIC_TX_PAD && s_q.padLeft == 2'h1
        |=> s_q.encState == FIC_ENC_RESET ##0 s_q.txState == FIC_TX_SEND)
        else $error("coder memory not zero after padding");
    a_pad_discarded: assert property (
        s_q.rxState == FIC_RX_PUSH && s_q.byteIdx > {1'b0, s_q.lenQ} |-> !qIn.valid)
        else $error("pad byte reached receive queue");
    a_rx_mode_follows: assert property (
        rxStart |=> s_q.rxCodedMode == $past(errorCorrectionEnable))
        else $error("receive coding mode not taken from enable");
    a_term_byte_added: assert property (
        txTake && errorCorrectionEnable && txCoded && txLast |=> s_q.padLeft != 2'h0)
        else $error("no termination byte after last coded byte");
    a_rx_even_total: assert property (
        rxStart && errorCorrectionEnable |=> s_q.byteTotal > {1'b0, s_q.lenQ} && !s_q.byteTotal[0])
        else $error("coded receive total not even or no pad");
    a_rx_plain_total: assert property (
        rxStart && !errorCorrectionEnable |=> s_q.byteTotal == {1'b0, s_q.lenQ})
        else $error("plain receive expects extra bytes");
    a_rx_queue_wait: assert property (
        s_q.rxState == FIC_RX_PUSH && s_q.pushKeep && !qIn.ready && !rxStart
        |=> s_q.rxState == FIC_RX_PUSH && !rxBitReady)
        else $error("kept byte lost while queue full");
    a_tx_bit_holds: assert property (
        txBitValid && !txBitReady |=> txBitValid && $stable(txBit))
        else $error("offered bit changed before taken");

    c_tx_padded_end: cover property (s_q.txState == FIC_TX_PAD ##[1:64] txDone);
    c_rx_drop_pad:   cover property (s_q.rxState == FIC_RX_PUSH && !s_q.pushKeep);
    c_rx_err_seen:   cover property (rxCodeErr);

endmodule : fic_codec

/* tb/fic_far_side.sv */
/*
 * fic_far_side: modem bit stream and receive queue reader facing the codec.
 * Assumes the ref_clk domain; the bench loads rxFeed and sets hold.
 */
`timescale 1ns/100ps
module fic_far_side (
    input  wire logic ref_clk,     // codec clock
    input  wire logic resetn,      // async reset, active low
    output logic      txBitReady,  // modem takes the bit
    output logic      rxBitValid,  // bit to codec valid
    output logic      rxBit,       // bit to codec
    input  wire logic rxBitReady,  // codec takes the bit
    output logic      rxByteReady  // queue reader ready
);
    logic rxFeed [$];  // bits still to send
    logic hold = 1'b0; // reader stalls while set

    // ************************************************************
    // random stalls; idle data toggles so a stale bit never looks valid
    // ************************************************************
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            txBitReady  <= 1'b0;
            rxBitValid  <= 1'b0;
            rxBit       <= 1'b0;
            rxByteReady <= 1'b0;
        end else begin
            txBitReady  <= ($urandom_range(3) != 0);
            rxByteReady <= !hold && ($urandom_range(2) != 0);
            // a bit offered stays until the codec takes it
            if (!rxBitValid || rxBitReady) begin
                if (rxFeed.size() != 0 && $urandom_range(3) != 0) begin
                    rxBitValid <= 1'b1;
                    rxBit      <= rxFeed.pop_front();
                end else begin
                    rxBitValid <= 1'b0;
                    rxBit      <= ~rxBit;
                end
            end
        end
    end
endmodule : fic_far_side

/* tb/fic_codec_bench.sv */
/*
 * fic_codec_bench: self-checking bench for fic_codec with a far side model.
 * Assumes fic_pkg and fic_far_side are compiled first.
 */
`timescale 1ns/100ps
module fic_codec_bench
    import fic_pkg::*;
;
    logic       ref_clk = 1'b0, resetn = 1'b0, errorCorrectionEnable = 1'b0;
    logic       txValid = 1'b0, txLast = 1'b0, txCoded = 1'b0, rxStart = 1'b0;
    logic [7:0] txData = 8'h00, rxLen = 8'h00, rxByteData;
    logic       txReady, txBitValid, txBit, txBitReady, rxBitValid, rxBit;
    logic       rxBitReady, rxByteValid, rxByteReady, rxCodeErr;
    logic       expTx [$];
    logic [7:0] expRx [$];
    int         errorCnt = 0, checksDone = 0, codeErrs = 0;

    always #50 ref_clk = ~ref_clk;

    fic_codec u_dut (.ref_clk(ref_clk), .resetn(resetn),
        .errorCorrectionEnable(errorCorrectionEnable), .txValid(txValid), .txData(txData),
        .txLast(txLast), .txCoded(txCoded), .txReady(txReady), .txBitValid(txBitValid),
        .txBit(txBit), .txBitReady(txBitReady), .rxStart(rxStart), .rxLen(rxLen),
        .rxBitValid(rxBitValid), .rxBit(rxBit), .rxBitReady(rxBitReady),
        .rxByteValid(rxByteValid), .rxByteData(rxByteData), .rxByteReady(rxByteReady),
        .rxCodeErr(rxCodeErr));
    fic_far_side u_far (.ref_clk(ref_clk), .resetn(resetn), .txBitReady(txBitReady),
        .rxBitValid(rxBitValid), .rxBit(rxBit), .rxBitReady(rxBitReady),
        .rxByteReady(rxByteReady));

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errorCnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // independent coder: taps u and u^s0^s2, rows in, columns out
    function automatic logic [15:0] encTx(input logic [7:0] b, inout logic [2:0] s);
        logic [15:0] c;
        logic [15:0] o;
        logic [3:0]  j;
        for (int i = 0; i < 8; i++) begin
            c[2*i]   = b[7-i];
            c[2*i+1] = b[7-i] ^ s[2] ^ s[0];
            s        = {b[7-i], s[2:1]};
        end
        for (int k = 0; k < 16; k++) begin
            j    = 4'(k);
            o[k] = c[{j[1:0], j[3:2]}];
        end
        return o;
    endfunction : encTx

    // one byte offered until taken; valid stays up for the next byte
    task automatic sendByte(input logic [7:0] b, input logic last, input logic coded);
        int g;
        g = 0;
        txData  = b;
        txLast  = last;
        txCoded = coded;
        txValid = 1'b1;
        while (txReady !== 1'b1 && g < 500) begin
            @(posedge ref_clk) #1;
            g++;
        end
        @(posedge ref_clk) #1;
    endtask : sendByte

    // header byte plain, then n data bytes; pads after the last when coding
    task automatic txPacket(input int n, input logic fec);
        logic [2:0]  s;
        logic [7:0]  b;
        logic [15:0] w;
        int          g;
        s = 3'h0;
        g = 0;
        errorCorrectionEnable = fec;
        b = 8'($urandom);
        for (int i = 7; i >= 0; i--) expTx.push_back(b[i]);
        sendByte(b, 1'b0, 1'b0);
        for (int k = 0; k < n + (fec ? 2 - n % 2 : 0); k++) begin
            b = (k < n) ? 8'($urandom) : 8'h00;
            w = encTx(b, s);
            if (fec) for (int i = 0; i < 16; i++) expTx.push_back(w[i]);
            else for (int i = 7; i >= 0; i--) expTx.push_back(b[i]);
            if (k < n) sendByte(b, k == n - 1, 1'b1);
        end
        txValid = 1'b0;
        while ((expTx.size() != 0 || txReady !== 1'b1) && g < 5000) begin
            @(posedge ref_clk) #1;
            g++;
        end
        check("txLeft", 16'(expTx.size()), 16'h0000);
    endtask : txPacket

    // fixed length packet into the receiver; flip spoils one parity bit
    task automatic rxPacket(input int n, input logic fec, input logic flip);
        logic [2:0]  s;
        logic [7:0]  b;
        logic [15:0] w;
        int          g, e0;
        s  = 3'h0;
        g  = 0;
        e0 = codeErrs;
        errorCorrectionEnable = fec;
        rxLen   = 8'(n);
        rxStart = 1'b1;
        u_far.hold = (n > FIC_FIFO_DEPTH);
        @(posedge ref_clk) #1;
        rxStart = 1'b0;
        for (int k = 0; k < n + (fec ? 2 - n % 2 : 0); k++) begin
            b = (k < n) ? 8'($urandom) : 8'h00;
            if (k < n) expRx.push_back(b);
            w = encTx(b, s);
            w[4] = w[4] ^ (flip && k == 0);
            if (fec) for (int i = 0; i < 16; i++) u_far.rxFeed.push_back(w[i]);
            else for (int i = 7; i >= 0; i--) u_far.rxFeed.push_back(b[i]);
        end
        if (u_far.hold) begin
            repeat (n * 48) @(posedge ref_clk);
            #1;
            check("fullStall", {rxBitReady, rxByteValid}, 16'h0001);
            u_far.hold = 1'b0;
        end
        while ((expRx.size() != 0 || u_far.rxFeed.size() != 0) && g < 20000) begin
            @(posedge ref_clk) #1;
            g++;
        end
        repeat (8) @(posedge ref_clk);
        #1;
        check("rxDrained", {expRx.size() != 0, rxByteValid}, 16'h0000);
        check("codeErr", 16'(codeErrs - e0), 16'(flip));
    endtask : rxPacket

    // ************************************************************
    // result monitor: oldest note against each transfer seen
    // ************************************************************
    always @(posedge ref_clk) begin
        if (resetn && txBitValid && txBitReady) begin
            if (expTx.size() == 0) check("txExtra", 16'h0001, 16'h0000);
            else check("txBit", txBit, expTx.pop_front());
        end
        if (resetn && rxByteValid && rxByteReady) begin
            if (expRx.size() == 0) check("rxExtra", 16'h0001, 16'h0000);
            else check("rxByte", rxByteData, expRx.pop_front());
        end
        if (resetn && rxCodeErr === 1'b1) codeErrs++;
    end

    task automatic conclude();
        $display("checks %0d errors %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude

    // hang guard, well beyond the expected run
    initial begin
        repeat (60000) @(posedge ref_clk);
        errorCnt++;
        conclude();
    end

    // payloads stay at two bytes or more while coding
    initial begin
        void'($urandom(32'h8d635274));
        repeat (16) @(posedge ref_clk);
        #1;
        resetn = 1'b1;
        txPacket(3, 1'b1);
        txPacket(2, 1'b1);
        txPacket(4, 1'b0);
        rxPacket(3, 1'b1, 1'b0);
        rxPacket(2, 1'b1, 1'b1);
        rxPacket(5, 1'b0, 1'b0);
        rxPacket(FIC_FIFO_DEPTH + 2, 1'b1, 1'b0);
        conclude();
    end
endmodule : fic_codec_bench
